/* inc/tdp_defines.svh */
`ifndef TDP_DEFINES_SVH
`define TDP_DEFINES_SVH

// Lane count and per-lane field widths
`define TDP_LANES 4
`define TDP_LANE_SEL_W 3
// Configuration port address and data widths
`define TDP_CFG_ADDR_W 9
`define TDP_CFG_DATA_W 16
// Reserved PCS input bus width, lane stride and bit taken per lane
`define TDP_RSVD_W 64
`define TDP_RSVD_STRIDE 16
`define TDP_RSVD_BIT 2
// Core clock rate in MHz
`define TDP_CLK_MHZ 25
// Settle times of the reset sequence in ns
`define TDP_PMA_SETTLE_NS 200
`define TDP_PCS_SETTLE_NS 120
// Least times round up to whole cycles, never below one
`define TDP_NS2CYC(ns) \
    ((((ns) * `TDP_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
    (((ns) * `TDP_CLK_MHZ + 999) / 1000))
`define TDP_PMA_CYC `TDP_NS2CYC(`TDP_PMA_SETTLE_NS)
`define TDP_PCS_CYC `TDP_NS2CYC(`TDP_PCS_SETTLE_NS)
// Width of the settle counters
`define TDP_CNT_W 8

`endif

/* inc/tdp_pkg.sv */
package tdp_pkg;

    // Reset sequencer states
    typedef enum logic [1:0] {
        SEQ_PMA_HOLD = 2'b00,
        SEQ_PMA_WAIT = 2'b01,
        SEQ_PCS_WAIT = 2'b10,
        SEQ_READY    = 2'b11
    } tdp_seq_state_t;

    // Eye-scan states
    typedef enum logic [1:0] {
        ES_IDLE  = 2'b00,
        ES_ARMED = 2'b01,
        ES_COUNT = 2'b10
    } tdp_es_state_t;

endpackage

/* core/tdp_reset_seq.sv */
`timescale 1ns/10ps
`include "tdp_defines.svh"

module tdp_reset_seq #(
    parameter int PMA_CYC = `TDP_PMA_CYC,
    parameter int PCS_CYC = `TDP_PCS_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Synchronised requests and PLL state
    input wire logic pma_req_i,
    input wire logic pcs_req_i,
    input wire logic pll_locked_i,
    // Status
    output logic pma_done_o,
    output logic seq_done_o
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if (PMA_CYC < 1 || PCS_CYC < 1 ||
        PMA_CYC >= (1 << `TDP_CNT_W) || PCS_CYC >= (1 << `TDP_CNT_W)) begin
        $error("Settle counts out of counter range");
    end

    localparam logic [`TDP_CNT_W-1:0] PMA_LOAD = PMA_CYC[`TDP_CNT_W-1:0];
    localparam logic [`TDP_CNT_W-1:0] PCS_LOAD = PCS_CYC[`TDP_CNT_W-1:0];

    tdp_pkg::tdp_seq_state_t state_q, state_d; // Sequencer state
    logic [`TDP_CNT_W-1:0] cnt_q, cnt_d; // Settle counter
    logic pma_done_q, pma_done_d; // PMA part finished
    logic done_q, done_d; // Whole sequence finished

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            // PMA held while requested or PLL unlocked
            tdp_pkg::SEQ_PMA_HOLD: begin
                cnt_d = PMA_LOAD;
                if (!pma_req_i && pll_locked_i) begin
                    state_d = tdp_pkg::SEQ_PMA_WAIT;
                end
            end
            // PMA settling
            tdp_pkg::SEQ_PMA_WAIT: begin
                if (cnt_q == 1) begin
                    state_d = tdp_pkg::SEQ_PCS_WAIT;
                    cnt_d = PCS_LOAD;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            // PCS settling, restarted while PCS request stays high
            tdp_pkg::SEQ_PCS_WAIT: begin
                if (pcs_req_i) begin
                    cnt_d = PCS_LOAD;
                end else if (cnt_q == 1) begin
                    state_d = tdp_pkg::SEQ_READY;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            // Usable; a PCS request only redoes the PCS part
            tdp_pkg::SEQ_READY: begin
                if (pcs_req_i) begin
                    state_d = tdp_pkg::SEQ_PCS_WAIT;
                    cnt_d = PCS_LOAD;
                end
            end
        endcase
        // A PMA request or lost lock restarts everything
        if (pma_req_i || !pll_locked_i) begin
            state_d = tdp_pkg::SEQ_PMA_HOLD;
        end
        pma_done_d = (state_d == tdp_pkg::SEQ_PCS_WAIT) ||
            (state_d == tdp_pkg::SEQ_READY);
        done_d = (state_d == tdp_pkg::SEQ_READY);
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= tdp_pkg::SEQ_PMA_HOLD;
            cnt_q <= '0;
            pma_done_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pma_done_q <= pma_done_d;
            done_q <= done_d;
        end
    end

    assign pma_done_o = pma_done_q;
    assign seq_done_o = done_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_req_clears_done;
        @(posedge clk_i) disable iff (sys_rst_i)
        pma_req_i |=> !seq_done_o && !pma_done_o;
    endproperty
    a_req_clears_done: assert property (p_req_clears_done)
        else $error("Done stays high during a PMA request");

    property p_done_after_pcs;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(seq_done_o) |-> $past(state_q) == tdp_pkg::SEQ_PCS_WAIT
            && $past(cnt_q) == 1 && $past(pll_locked_i);
    endproperty
    a_done_after_pcs: assert property (p_done_after_pcs)
        else $error("Done rose without finishing the PCS wait");

    c_seq_done: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(seq_done_o));

endmodule

/* core/tdp_debug_port.sv */
`timescale 1ns/10ps
`include "tdp_defines.svh"

// Function
// - Pulse channel 3 done after each access
// - Bits 2,18,34,50 feed lane reserved bit 2
// - TX PMA/PCS requests restart transmit reset
// - RX PMA/PCS requests restart receive reset
// - Transmit reset-done per lane, core clock
// - Receive reset-done per lane, core clock
// - Phase init, align, delay reset done outputs
// - PLL lock output while within tolerance
// - Eye-scan trigger input causes trigger event while armed
// - Error pulse one cycle while armed/counting
// - Twelve-bit receive divider select, three per lane
// - Twelve-bit loopback select, three per lane
// - Nine-bit address, sixteen-bit data buses

module tdp_debug_port #(
    parameter int LANES = `TDP_LANES,
    parameter int CFG_ADDR_W = `TDP_CFG_ADDR_W,
    parameter int CFG_DATA_W = `TDP_CFG_DATA_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Channel 3 configuration port
    input wire logic ch3_cfg_enable_i,
    input wire logic ch3_cfg_write_select_i,
    input wire logic [CFG_ADDR_W-1:0] ch3_cfg_addr_i,
    input wire logic [CFG_DATA_W-1:0] ch3_cfg_wdata_i,
    output logic [CFG_DATA_W-1:0] ch3_cfg_rdata_o,
    output logic ch3_cfg_access_done_o,
    // Reserved PCS inputs (async) and per-lane reserved bit 2
    input wire logic [`TDP_RSVD_W-1:0] reserved_pcs_input_bus_i,
    output logic [LANES-1:0] lane_reserved_bit2_o,
    // Reset requests (async)
    input wire logic [LANES-1:0] tx_pma_reset_request_i,
    input wire logic [LANES-1:0] tx_pcs_reset_request_i,
    input wire logic [LANES-1:0] rx_pma_reset_request_i,
    input wire logic [LANES-1:0] rx_pcs_reset_request_i,
    // Reset status
    output logic [LANES-1:0] tx_reset_complete_o,
    output logic [LANES-1:0] rx_reset_complete_o,
    output logic [LANES-1:0] rx_pma_reset_complete_o,
    // Clocking status
    input wire logic [LANES*`TDP_LANE_SEL_W-1:0] lane_rx_buffer_raw_i,
    output logic [LANES*`TDP_LANE_SEL_W-1:0] rx_buffer_state_o,
    output logic [LANES-1:0] tx_phase_align_complete_o,
    output logic [LANES-1:0] tx_phase_init_complete_o,
    output logic [LANES-1:0] tx_delay_soft_reset_complete_o,
    input wire logic pll_in_tolerance_i,
    output logic shared_pll_locked_o,
    // Eye scan
    input wire logic [LANES-1:0] eye_scan_trigger_in_i,
    input wire logic [LANES-1:0] eye_scan_reset_in_i,
    input wire logic [LANES-1:0] lane_bit_error_i,
    input wire logic [LANES-1:0] lane_error_mask_i,
    output logic [LANES-1:0] eye_scan_trigger_event_o,
    output logic [LANES-1:0] eye_scan_error_out_o,
    // Rate and loopback
    input wire logic [LANES*`TDP_LANE_SEL_W-1:0] rx_divider_select_i,
    output logic [LANES*`TDP_LANE_SEL_W-1:0] lane_rx_divider_o,
    input wire logic [LANES*`TDP_LANE_SEL_W-1:0] loopback_select_i,
    output logic [LANES*`TDP_LANE_SEL_W-1:0] lane_loopback_o
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if (LANES != `TDP_LANES || CFG_ADDR_W != `TDP_CFG_ADDR_W ||
        CFG_DATA_W != `TDP_CFG_DATA_W) begin
        $error("Lane count and port widths are fixed by the lane map");
    end

    localparam int SW = LANES * `TDP_LANE_SEL_W; // Per-lane field bus width

    // Picks the reserved bit of each lane from the wide bus
    function automatic logic [LANES-1:0] rsvd_pick(
        input logic [`TDP_RSVD_W-1:0] bus);
        logic [LANES-1:0] r;
        r = '0;
        for (int l = 0; l < LANES; l++) begin
            r[l] = bus[l * `TDP_RSVD_STRIDE + `TDP_RSVD_BIT];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Channel 3 configuration port
    logic [CFG_DATA_W-1:0] cfg_mem [1 << CFG_ADDR_W]; // Config space
    logic cfg_done_q, cfg_done_d; // Done pulse
    logic [CFG_DATA_W-1:0] cfg_rdata_q, cfg_rdata_d; // Read data

    // Done one cycle after enable; read data captured on reads
    always_comb begin
        cfg_done_d = ch3_cfg_enable_i;
        cfg_rdata_d = cfg_rdata_q;
        if (ch3_cfg_enable_i && !ch3_cfg_write_select_i) begin
            cfg_rdata_d = cfg_mem[ch3_cfg_addr_i];
        end
    end

    // Config registers; the memory itself has no reset
    always_ff @(posedge clk_i) begin
        if (ch3_cfg_enable_i && ch3_cfg_write_select_i) begin
            cfg_mem[ch3_cfg_addr_i] <= ch3_cfg_wdata_i;
        end
        if (sys_rst_i) begin
            cfg_done_q <= 1'b0;
            cfg_rdata_q <= '0;
        end else begin
            cfg_done_q <= cfg_done_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    assign ch3_cfg_access_done_o = cfg_done_q;
    assign ch3_cfg_rdata_o = cfg_rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for reserved, reset request, eye-scan reset, bit error, loopback and PLL inputs
    localparam int AW = 7 * LANES + SW + 1; // Async bundle width
    logic [AW-1:0] async_in; // Raw async bundle
    logic [AW-1:0] meta_q; // First stage
    logic [AW-1:0] sync_q; // Second stage
    logic [LANES-1:0] s_rsvd, s_txpma, s_txpcs, s_rxpma, s_rxpcs;
    logic [LANES-1:0] s_esrst, s_err;
    logic [SW-1:0] s_loop;
    logic s_pll;

    assign async_in = {rsvd_pick(reserved_pcs_input_bus_i),
        tx_pma_reset_request_i, tx_pcs_reset_request_i,
        rx_pma_reset_request_i, rx_pcs_reset_request_i,
        eye_scan_reset_in_i, lane_bit_error_i,
        loopback_select_i, pll_in_tolerance_i};

    // Sample twice before use
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign {s_rsvd, s_txpma, s_txpcs, s_rxpma, s_rxpcs, s_esrst, s_err,
        s_loop, s_pll} = sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-lane reset sequencers
    logic [LANES-1:0] tx_done, rx_done, rx_pma_done;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        // Transmit side
        tdp_reset_seq u_tx_seq (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .pma_req_i(s_txpma[l]),
            .pcs_req_i(s_txpcs[l]),
            .pll_locked_i(s_pll),
            .pma_done_o(),
            .seq_done_o(tx_done[l])
        );
        // Receive side
        tdp_reset_seq u_rx_seq (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .pma_req_i(s_rxpma[l]),
            .pcs_req_i(s_rxpcs[l]),
            .pll_locked_i(s_pll),
            .pma_done_o(rx_pma_done[l]),
            .seq_done_o(rx_done[l])
        );
    end

    assign tx_reset_complete_o = tx_done;
    assign rx_reset_complete_o = rx_done;
    assign rx_pma_reset_complete_o = rx_pma_done;

    ////////////////////////////////////////////////////////////////////////
    // Status, alignment chain, rate, loopback, eye scan
    logic [LANES-1:0] dly_q, dly_d; // Delay soft reset done
    logic [LANES-1:0] init_q, init_d; // Phase init done
    logic [LANES-1:0] align_q, align_d; // Phase align done
    logic pll_q, pll_d; // Registered lock
    logic [LANES-1:0] rsvd_q, rsvd_d; // Lane reserved bits
    logic [SW-1:0] buf_q, buf_d; // Receive buffer state
    logic [SW-1:0] rate_q, rate_d; // Divider select
    logic [SW-1:0] loop_q, loop_d; // Loopback select
    logic [LANES-1:0] esrst_prev_q, esrst_prev_d; // Eye reset history
    logic [LANES-1:0] err_prev_q, err_prev_d; // Error history
    logic [LANES-1:0] trig_ev_q, trig_ev_d; // Trigger event pulse
    logic [LANES-1:0] es_err_q, es_err_d; // Error pulse
    tdp_pkg::tdp_es_state_t es_q [LANES]; // Eye-scan state
    tdp_pkg::tdp_es_state_t es_d [LANES];

    // Next values of all status and eye-scan state
    always_comb begin
        // Alignment steps follow transmit done one per cycle
        dly_d = tx_done;
        init_d = dly_q & tx_done;
        align_d = init_q & tx_done;
        pll_d = s_pll;
        rsvd_d = s_rsvd;
        rate_d = rx_divider_select_i;
        loop_d = s_loop;
        esrst_prev_d = s_esrst;
        err_prev_d = s_err;
        for (int l = 0; l < LANES; l++) begin
            // Buffer state reads zero until the receiver is usable
            buf_d[l*`TDP_LANE_SEL_W +: `TDP_LANE_SEL_W] = rx_done[l] ?
                lane_rx_buffer_raw_i[l*`TDP_LANE_SEL_W +: `TDP_LANE_SEL_W] :
                '0;
            es_d[l] = es_q[l];
            trig_ev_d[l] = 1'b0;
            if (s_esrst[l]) begin
                // Held idle while reset is high
                es_d[l] = tdp_pkg::ES_IDLE;
            end else if (esrst_prev_q[l]) begin
                // Reset released: arm
                es_d[l] = tdp_pkg::ES_ARMED;
            end else if (eye_scan_trigger_in_i[l] &&
                es_q[l] == tdp_pkg::ES_ARMED) begin
                // Trigger moves armed scan into counting
                es_d[l] = tdp_pkg::ES_COUNT;
                trig_ev_d[l] = 1'b1;
            end
            // Each new unmasked error gives one pulse when active
            es_err_d[l] = s_err[l] && !err_prev_q[l] &&
                !lane_error_mask_i[l] &&
                (es_q[l] == tdp_pkg::ES_ARMED ||
                es_q[l] == tdp_pkg::ES_COUNT);
        end
    end

    // Status registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dly_q <= '0;
            init_q <= '0;
            align_q <= '0;
            pll_q <= 1'b0;
            rsvd_q <= '0;
            buf_q <= '0;
            rate_q <= '0;
            loop_q <= '0;
            esrst_prev_q <= '0;
            err_prev_q <= '0;
            trig_ev_q <= '0;
            es_err_q <= '0;
            for (int l = 0; l < LANES; l++) begin
                es_q[l] <= tdp_pkg::ES_IDLE;
            end
        end else begin
            dly_q <= dly_d;
            init_q <= init_d;
            align_q <= align_d;
            pll_q <= pll_d;
            rsvd_q <= rsvd_d;
            buf_q <= buf_d;
            rate_q <= rate_d;
            loop_q <= loop_d;
            esrst_prev_q <= esrst_prev_d;
            err_prev_q <= err_prev_d;
            trig_ev_q <= trig_ev_d;
            es_err_q <= es_err_d;
            es_q <= es_d;
        end
    end

    assign tx_delay_soft_reset_complete_o = dly_q;
    assign tx_phase_init_complete_o = init_q;
    assign tx_phase_align_complete_o = align_q;
    assign shared_pll_locked_o = pll_q;
    assign lane_reserved_bit2_o = rsvd_q;
    assign rx_buffer_state_o = buf_q;
    assign lane_rx_divider_o = rate_q;
    assign lane_loopback_o = loop_q;
    assign eye_scan_trigger_event_o = trig_ev_q;
    assign eye_scan_error_out_o = es_err_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_cfg_done;
        ch3_cfg_enable_i |=> ch3_cfg_access_done_o;
    endproperty
    a_cfg_done: assert property (p_cfg_done)
        else $error("No done pulse after a config access");

    // Write, two idle cycles, read of the same word returns the write
    property p_cfg_read;
        ch3_cfg_enable_i && ch3_cfg_write_select_i ##1
            !ch3_cfg_enable_i [*2] ##1
            ch3_cfg_enable_i && !ch3_cfg_write_select_i &&
            ch3_cfg_addr_i == $past(ch3_cfg_addr_i, 3)
            |=> ch3_cfg_rdata_o == $past(ch3_cfg_wdata_i, 4);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("Config readback differs from written data");

    property p_rsvd_map;
        ##3 lane_reserved_bit2_o == {
            $past(reserved_pcs_input_bus_i[50], 3),
            $past(reserved_pcs_input_bus_i[34], 3),
            $past(reserved_pcs_input_bus_i[18], 3),
            $past(reserved_pcs_input_bus_i[2], 3)};
    endproperty
    a_rsvd_map: assert property (p_rsvd_map)
        else $error("Reserved bit routed to wrong lane");

    property p_pll_follow;
        $stable(pll_in_tolerance_i) [*4] |-> shared_pll_locked_o ==
            pll_in_tolerance_i;
    endproperty
    a_pll_follow: assert property (p_pll_follow)
        else $error("PLL lock output does not follow tolerance");

    property p_es_err_state;
        |eye_scan_error_out_o |-> $past(es_q[0]) != tdp_pkg::ES_IDLE ||
            $past(es_q[1]) != tdp_pkg::ES_IDLE ||
            $past(es_q[2]) != tdp_pkg::ES_IDLE ||
            $past(es_q[3]) != tdp_pkg::ES_IDLE;
    endproperty
    a_es_err_state: assert property (p_es_err_state)
        else $error("Eye-scan error while idle");

    property p_es_err_single;
        eye_scan_error_out_o[0] |=> !eye_scan_error_out_o[0];
    endproperty
    a_es_err_single: assert property (p_es_err_single)
        else $error("Eye-scan error longer than one cycle");

    property p_rate;
        1'b1 |=> lane_rx_divider_o == $past(rx_divider_select_i);
    endproperty
    a_rate: assert property (p_rate)
        else $error("Divider select not applied");

    property p_align_order;
        |tx_phase_align_complete_o |->
            (tx_phase_align_complete_o & ~tx_phase_init_complete_o) == '0 &&
            (tx_phase_align_complete_o & ~$past(tx_reset_complete_o)) == '0;
    endproperty
    a_align_order: assert property (p_align_order)
        else $error("Phase align done out of order");

    property p_buf_zero;
        ##1 ((rx_buffer_state_o[2:0] != 3'h0) -> $past(rx_done[0]));
    endproperty
    a_buf_zero: assert property (p_buf_zero)
        else $error("Buffer state shown before receive reset done");

    c_cfg_write: cover property (ch3_cfg_enable_i &&
        ch3_cfg_write_select_i ##1 ch3_cfg_access_done_o);
    c_cfg_read: cover property (ch3_cfg_enable_i &&
        !ch3_cfg_write_select_i ##1 ch3_cfg_access_done_o);
    c_es_trigger: cover property (|eye_scan_trigger_event_o);
    c_es_error: cover property (|eye_scan_error_out_o);

endmodule

/* tb/tdp_fabric_model.sv */
`timescale 1ns/10ps
// Fabric side of the channel 3 configuration port
module tdp_fabric_model (
    // Clock and command from the bench
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic wr_i,
    input wire logic [8:0] addr_i,
    input wire logic [15:0] wdata_i,
    // Answer from the device
    input wire logic done_i,
    // Configuration port drive
    output logic en_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [8:0] addr_o = 9'h000,
    output logic [15:0] wdata_o = 16'h0000
);
    logic busy_q = 1'b0; // Access outstanding
    // One enable per access, next access only after done
    always @(posedge clk_i) begin
        if (go_i && !busy_q && !en_o) begin
            en_o <= 1'b1;
            we_o <= wr_i;
            addr_o <= addr_i;
            wdata_o <= wdata_i;
            busy_q <= 1'b1;
        end else if (en_o) begin
            en_o <= 1'b0;
            // Released buses show the inverse of the last values, never stale ones
            addr_o <= ~addr_o;
            wdata_o <= ~wdata_o;
        end
        if (done_i) begin
            busy_q <= 1'b0;
        end
    end
endmodule

/* tb/tdp_debug_port_tb.sv */
`timescale 1ns/10ps
module tdp_debug_port_tb;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0, pll = 1'b1;
    logic en, we, done, lock;
    logic [8:0] ad = 9'h000, ca;
    logic [15:0] wd = 16'h0000, cw, rd;
    logic [63:0] rsv = 64'h0;
    logic [3:0] txpma = 4'h0, txpcs = 4'h0, rxpma = 4'h0, rxpcs = 4'h0;
    logic [3:0] trg = 4'h0, esr = 4'h0, berr = 4'h0, msk = 4'h0;
    logic [3:0] lrb, txd, rxd, rxpd, pa, pi, pd, tev, eer, m;
    logic [11:0] braw = 12'h0, div = 12'h0, lb = 12'h0, bst, ldiv, llb;
    int fails = 0, num_checks = 0, cyc = 0;

    always #20 clk = ~clk;

    tdp_fabric_model u_tdp_fabric_model (.clk_i(clk), .go_i(go),
        .wr_i(wr), .addr_i(ad), .wdata_i(wd), .done_i(done), .en_o(en),
        .we_o(we), .addr_o(ca), .wdata_o(cw));

    tdp_debug_port u_tdp_debug_port (.clk_i(clk), .sys_rst_i(rst),
        .ch3_cfg_enable_i(en), .ch3_cfg_write_select_i(we),
        .ch3_cfg_addr_i(ca), .ch3_cfg_wdata_i(cw), .ch3_cfg_rdata_o(rd),
        .ch3_cfg_access_done_o(done), .reserved_pcs_input_bus_i(rsv),
        .lane_reserved_bit2_o(lrb), .tx_pma_reset_request_i(txpma),
        .tx_pcs_reset_request_i(txpcs), .rx_pma_reset_request_i(rxpma),
        .rx_pcs_reset_request_i(rxpcs), .tx_reset_complete_o(txd),
        .rx_reset_complete_o(rxd), .rx_pma_reset_complete_o(rxpd),
        .lane_rx_buffer_raw_i(braw), .rx_buffer_state_o(bst),
        .tx_phase_align_complete_o(pa), .tx_phase_init_complete_o(pi),
        .tx_delay_soft_reset_complete_o(pd), .pll_in_tolerance_i(pll),
        .shared_pll_locked_o(lock), .eye_scan_trigger_in_i(trg),
        .eye_scan_reset_in_i(esr), .lane_bit_error_i(berr),
        .lane_error_mask_i(msk), .eye_scan_trigger_event_o(tev),
        .eye_scan_error_out_o(eer), .rx_divider_select_i(div),
        .lane_rx_divider_o(ldiv), .loopback_select_i(lb),
        .lane_loopback_o(llb));

    ////////////////////////////////////////////////////////////////
    // Compare, wait and close
    task chk(input logic [15:0] s, input logic [15:0] e, input string t);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %0t %s", $time, t);
        end
    endtask
    task nw(input int n);
        repeat (n) @(negedge clk);
    endtask
    task give_verdict;
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict;
        end
    end

    ////////////////////////////////////////////////////////////////
    // One configuration access, done must follow the enable by one
    task cfg(input logic w, input logic [8:0] a, input logic [15:0] d);
        int k;
        go = 1'b1;
        wr = w;
        ad = a;
        wd = d;
        nw(1);
        go = 1'b0;
        k = 1;
        while (done !== 1'b1 && k < 9) begin
            nw(1);
            k++;
        end
        chk(16'(k), 16'h2, "done latency");
        if (!w) chk(rd, d, "read data");
        nw(1);
        chk(16'(done), 16'h0, "done width");
    endtask
    // Pulse count per lane for lanes 0 and 1 over eight cycles
    task cnt(input logic e, output int c0, output int c1);
        c0 = 0;
        c1 = 0;
        repeat (8) begin
            @(negedge clk);
            trg = 4'h0;
            m = e ? eer : tev;
            c0 += m[0];
            c1 += m[1];
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_cfg;
        cfg(1'b1, 9'h1ff, 16'ha5c3);
        cfg(1'b0, 9'h1ff, 16'ha5c3);
        cfg(1'b1, 9'h000, 16'h3c5a);
        cfg(1'b0, 9'h000, 16'h3c5a);
    endtask
    task t_rst;
        chk({pa, pi, pd, lock}, 16'h1fff, "align or lock");
        for (int k = 0; k < 4; k++) begin
            {rxpcs, rxpma, txpcs, txpma} = 16'h1 << (5 * k);
            m = ~(4'h1 << k);
            nw(6);
            chk(txd, k < 2 ? m : 4'hf, "tx done");
            chk(pa & pi & pd, k < 2 ? m : 4'hf, "align");
            chk(rxd, k > 1 ? m : 4'hf, "rx done");
            chk(rxpd, k == 2 ? m : 4'hf, "rx pma done");
            {rxpcs, rxpma, txpcs, txpma} = 16'h0;
            nw(30);
            chk({rxpd, rxd, txd}, 16'hfff, "done back");
        end
    endtask
    task t_pll;
        pll = 1'b0;
        nw(6);
        chk({lock, txd}, 16'h0, "lock loss");
        pll = 1'b1;
        nw(30);
        chk({lock, txd, rxd}, 16'h1ff, "relock");
    endtask
    task t_misc;
        int c0, c1;
        rsv = 64'h0004_0000_0006_0008;
        div = 12'ha53;
        lb = 12'h5ac;
        braw = 12'h3e7;
        nw(4);
        chk(lrb, 4'ha, "reserved");
        chk(ldiv, div, "divider");
        chk(llb, lb, "loopback");
        chk(bst, braw, "buffer");
        rsv = 64'h0000_0004_0000_0004;
        nw(4);
        chk(lrb, 4'h5, "reserved");
        esr = 4'h1;
        nw(4);
        esr = 4'h0;
        nw(6);
        trg = 4'h3;
        cnt(1'b0, c0, c1);
        chk(16'(c0 * 2 + c1), 16'h2, "trigger");
        berr = 4'h3;
        cnt(1'b1, c0, c1);
        chk(16'(c0 * 2 + c1), 16'h2, "error");
        berr = 4'h0;
        msk = 4'h1;
        nw(2);
        berr = 4'h1;
        cnt(1'b1, c0, c1);
        chk(16'(c0), 16'h0, "masked");
    endtask

    initial begin
        nw(5);
        rst = 1'b0;
        nw(30);
        t_cfg;
        t_rst;
        t_pll;
        t_misc;
        give_verdict;
    end
endmodule
